// File: logic/cgs_pkg.sv
// Constants and types for the clock gear and standby controller
package cgs_pkg;

  // Register map
  localparam logic [7:0] SYS0_ADDR = 8'hE0;
  localparam logic [7:0] SYS1_ADDR = 8'hE1;
  localparam logic [7:0] SYS2_ADDR = 8'hE2;
  localparam logic [7:0] STAT_ADDR = 8'hE3;
  localparam logic [7:0] KEY_ADDR  = 8'hE4;

  // system_control_zero fields
  localparam int SYS0_HIGH_EN = 7;
  localparam int SYS0_LOW_EN  = 6;
  localparam int SYS0_WARM    = 2;
  localparam int SYS0_PRESC   = 1;
  localparam logic [7:0] SYS0_MASK = 8'hC2;
  localparam logic [7:0] SYS0_RST  = 8'h80;

  // system_control_one fields
  localparam int SYS1_SRC     = 3;
  localparam int SYS1_GEAR_LO = 0;
  localparam logic [7:0] SYS1_MASK = 8'h0F;
  localparam logic [7:0] SYS1_RST  = 8'h00;

  // system_control_two fields
  localparam int SYS2_CLKSEL  = 6;
  localparam int SYS2_WSEL_LO = 4;
  localparam int SYS2_HALT_LO = 2;
  localparam int SYS2_DRIVE   = 0;
  localparam logic [7:0] SYS2_MASK = 8'h7D;
  localparam logic [7:0] SYS2_RST  = 8'h2C;

  // Protection
  localparam int PROT_BIT = 7;
  localparam logic [6:0] STAT_RST   = 7'h23;
  localparam logic       PROT_RST   = 1'b0;
  localparam logic [7:0] KEY_UNLOCK = 8'h1F;

  // Standby select codes
  localparam logic [1:0] HALT_STOP  = 2'b01;
  localparam logic [1:0] HALT_OSC_RTC_ONLY_HALT = 2'b10;
  localparam logic [1:0] HALT_CPU_ONLY_HALT = 2'b11;

  // Warm-up select codes and interval exponents
  localparam logic [1:0] WSEL_18 = 2'b00;
  localparam logic [1:0] WSEL_8  = 2'b01;
  localparam logic [1:0] WSEL_14 = 2'b10;
  localparam logic [1:0] WSEL_16 = 2'b11;
  localparam int WARM_W     = 18;
  localparam int WARM_EXP18 = 18;
  localparam int WARM_EXP8  = 8;
  localparam int WARM_EXP14 = 14;
  localparam int WARM_EXP16 = 16;

  // Dividers: gear 0..4, fc/64 prescaler path
  localparam int GEAR_W  = 4;
  localparam int PRESC_W = 6;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_CPU_ONLY_HALT = 3'b001,
    ST_OSC_RTC_ONLY_HALT = 3'b011,
    ST_STOP  = 3'b010,
    ST_WARM  = 3'b110
  } cgs_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cgs_bus_req_t;

endpackage

// File: logic/cgs_top.sv
// Clock gear, clock output, protection and standby controller
//
// Our own choice: strobed register access.
`timescale 1ns/1ps

// Behaviour
// - Writing one to warm bit restarts counter; bit reads one until done.
// - Warm select code 10 gives 2^14 cycles of the starting oscillator.
// - With high source, gear divides high clock by 1,2,4,8,16 for peripheral clock.
// - New gear setting takes effect only after a delay.
// - Pin becomes clock output only when direction and function bits set.
// - Clock select zero routes low clock, one routes system clock.
// - Prescaler input is peripheral clock/2 or high clock/64 by select.
// - Key 1FH unlocks; any other key value locks protected registers.
// - Lock covers the three system registers, not status or key.
// - Status bit 7 reads lock state, resets zero; other bits reset to 23H and are writable.
// - Halt enters standby chosen by field: 11, 10, 01.
// - Cpu-only halt stops cpu; units run only if their enable set.
// - Oscillator-and-RTC halt stops all but oscillator and RTC.
// - Full stop halts every circuit including the oscillator.
// - In idle halts port outputs keep their state at halt entry.
// - Reset: gear 000, high oscillator on, low off, high selected.
// - Standby exits by reset or qualifying interrupt request.
module cgs_top
#(
  parameter int NUM_UNITS = 15,
  parameter int EXP_W18   = cgs_pkg::WARM_EXP18,
  parameter int EXP_W8    = cgs_pkg::WARM_EXP8,
  parameter int EXP_W14   = cgs_pkg::WARM_EXP14,
  parameter int EXP_W16   = cgs_pkg::WARM_EXP16
)
(
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESET_N,
  input  wire cgs_pkg::cgs_bus_req_t  BUS,
  output logic [7:0]                  RDATA,
  input  wire logic                   HIGH_OSC_TICK,
  input  wire logic                   LOW_OSC_TICK,
  input  wire logic                   HALT_EXEC,
  input  wire logic                   WAKE_REQ,
  input  wire logic                   PIN_DIR_BIT,
  input  wire logic                   PIN_FUNC_BIT,
  input  wire logic                   PORT_DATA,
  input  wire logic [NUM_UNITS-1:0]   UNIT_IDLE_EN,
  output logic                        HIGH_OSC_ENABLE,
  output logic                        LOW_OSC_ENABLE,
  output logic                        PERIPH_TICK,
  output logic                        SYS_TICK,
  output logic                        PRESC_TICK,
  output logic                        CPU_RUN,
  output logic [NUM_UNITS-1:0]        UNIT_RUN,
  output logic                        RTC_RUN,
  output logic                        PORT_HOLD,
  output logic                        PROTECT_ON,
  output logic                        PIN_OUT,
  output logic                        PIN_OE_N
);
  import cgs_pkg::*;

  if (NUM_UNITS < 1 || EXP_W18 > WARM_W || EXP_W8 < 1 || EXP_W14 < 1 ||
      EXP_W16 < 1 || EXP_W18 < 1 || EXP_W8 > WARM_W ||
      EXP_W14 > WARM_W || EXP_W16 > WARM_W)
  begin : g_bad_params
    $error("cgs_top: parameter out of range");
  end

  // Registers, timers, dividers and sequencer state
  logic [7:0]          sys0, sys1, sys2, next_sys0, next_sys1, next_sys2;
  logic [6:0]          stat, next_stat;
  logic [7:0]          rdata, next_rdata;
  logic                prot, next_prot, warm_busy, next_warm_busy;
  logic [WARM_W-1:0]   warm_cnt, next_warm_cnt;
  logic [GEAR_W-1:0]   gear_cnt, next_gear_cnt;
  logic [2:0]          gear_act, next_gear_act;
  logic                phase, next_phase, clk_level, next_clk_level;
  logic [PRESC_W-1:0]  presc_cnt, next_presc_cnt;
  cgs_state_t          state, next_state;
  logic                held_data, next_held_data;
  logic                pin_out, next_pin_out, pin_oe_n, next_pin_oe_n;

  logic        wr_ok, warm_start, warm_tick, warm_done;
  logic        clocks_on, per_tick, sys_tick, presc_tick, out_tick;
  logic        src_low;
  logic [1:0]  halt_sel;

  function automatic logic [WARM_W-1:0] warm_last(input logic [1:0] sel);
    case (sel)
      WSEL_8:  return WARM_W'((1 << EXP_W8) - 1);
      WSEL_14: return WARM_W'((1 << EXP_W14) - 1);
      WSEL_16: return WARM_W'((1 << EXP_W16) - 1);
      default: return WARM_W'((1 << EXP_W18) - 1);
    endcase
  endfunction

  // Codes above 3 all divide by 16
  function automatic logic [GEAR_W-1:0] gear_mask(input logic [2:0] g);
    return (g > 3'h3) ? {GEAR_W{1'b1}} : GEAR_W'((1 << g) - 1);
  endfunction

  assign src_low  = sys1[SYS1_SRC];
  assign halt_sel = sys2[SYS2_HALT_LO +: 2];
  // Locked writes are silently dropped
  assign wr_ok    = BUS.wr && !prot;
  assign warm_start = (wr_ok && BUS.addr == SYS0_ADDR &&
                       BUS.wdata[SYS0_WARM]) ||
                      (state == ST_STOP && WAKE_REQ);
  // In warm state after stop counts the selected source; otherwise counts the oscillator not in use
  assign warm_tick = (state == ST_WARM) ?
                     (src_low ? LOW_OSC_TICK : HIGH_OSC_TICK) :
                     (src_low ? HIGH_OSC_TICK : LOW_OSC_TICK);
  assign warm_done = warm_busy && warm_tick &&
                     warm_cnt == warm_last(sys2[SYS2_WSEL_LO +: 2]);

  // System clock only runs in run and cpu-only halt
  assign clocks_on = (state == ST_RUN) || (state == ST_CPU_ONLY_HALT);
  assign per_tick  = clocks_on && (src_low ? LOW_OSC_TICK :
                     (HIGH_OSC_TICK &&
                      (gear_cnt & gear_mask(gear_act)) == '0));
  assign sys_tick  = per_tick && phase;
  assign presc_tick = sys0[SYS0_PRESC] ?
                      (clocks_on && HIGH_OSC_TICK && presc_cnt == '0) :
                      sys_tick;
  assign out_tick  = sys2[SYS2_CLKSEL] ? sys_tick : LOW_OSC_TICK;

  // Register file
  always_comb
  begin
    next_sys0  = sys0;
    next_sys1  = sys1;
    next_sys2  = sys2;
    next_stat  = stat;
    next_prot  = prot;
    next_rdata = 8'h00;
    if (wr_ok)
    begin
      case (BUS.addr)
        SYS0_ADDR: next_sys0 = BUS.wdata & SYS0_MASK;
        SYS1_ADDR: next_sys1 = BUS.wdata & SYS1_MASK;
        SYS2_ADDR: next_sys2 = BUS.wdata & SYS2_MASK;
        default:   next_sys0 = sys0;
      endcase
    end
    if (BUS.wr && BUS.addr == STAT_ADDR)
      next_stat = BUS.wdata[6:0];
    if (BUS.wr && BUS.addr == KEY_ADDR)
      next_prot = (BUS.wdata != KEY_UNLOCK);
    if (BUS.rd)
    begin
      case (BUS.addr)
        SYS0_ADDR: next_rdata = sys0 | {5'h00, warm_busy, 2'h0};
        SYS1_ADDR: next_rdata = sys1;
        SYS2_ADDR: next_rdata = sys2;
        STAT_ADDR: next_rdata = {prot, stat};
        default:   next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sys0  <= SYS0_RST;
      sys1  <= SYS1_RST;
      sys2  <= SYS2_RST;
      stat  <= STAT_RST;
      prot  <= PROT_RST;
      rdata <= 8'h00;
    end
    else
    begin
      sys0  <= next_sys0;
      sys1  <= next_sys1;
      sys2  <= next_sys2;
      stat  <= next_stat;
      prot  <= next_prot;
      rdata <= next_rdata;
    end
  end

  // Warm-up timer, restart wins over completion
  always_comb
  begin
    next_warm_busy = warm_busy;
    next_warm_cnt  = warm_cnt;
    if (warm_start)
    begin
      next_warm_busy = 1'b1;
      next_warm_cnt  = '0;
    end
    else if (warm_done)
      next_warm_busy = 1'b0;
    else if (warm_busy && warm_tick)
      next_warm_cnt = warm_cnt + 1'b1;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      warm_busy <= 1'b0;
      warm_cnt  <= '0;
    end
    else
    begin
      warm_busy <= next_warm_busy;
      warm_cnt  <= next_warm_cnt;
    end
  end

  // Gear divider, prescaler and clock output level
  always_comb
  begin
    next_gear_cnt  = gear_cnt;
    next_gear_act  = gear_act;
    next_phase     = phase;
    next_presc_cnt = presc_cnt;
    next_clk_level = clk_level;
    if (HIGH_OSC_TICK && clocks_on)
    begin
      next_gear_cnt  = gear_cnt + 1'b1;
      next_presc_cnt = presc_cnt + 1'b1;
      // With high source, gear swaps only at a full divider wrap
      if (gear_cnt == '0)
        next_gear_act = sys1[SYS1_GEAR_LO +: 3];
    end
    if (src_low)
      next_gear_act = sys1[SYS1_GEAR_LO +: 3];
    if (per_tick)
      next_phase = !phase;
    if (out_tick && state != ST_STOP && state != ST_WARM)
      next_clk_level = !clk_level;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      gear_cnt  <= '0;
      gear_act  <= 3'h0;
      phase     <= 1'b0;
      presc_cnt <= '0;
      clk_level <= 1'b0;
    end
    else
    begin
      gear_cnt  <= next_gear_cnt;
      gear_act  <= next_gear_act;
      phase     <= next_phase;
      presc_cnt <= next_presc_cnt;
      clk_level <= next_clk_level;
    end
  end

  // Standby sequencer and shared pin
  always_comb
  begin
    next_state     = state;
    next_held_data = held_data;
    case (state)
      ST_RUN:
      begin
        next_held_data = PORT_DATA;
        if (HALT_EXEC)
        begin
          case (halt_sel)
            HALT_CPU_ONLY_HALT: next_state = ST_CPU_ONLY_HALT;
            HALT_OSC_RTC_ONLY_HALT: next_state = ST_OSC_RTC_ONLY_HALT;
            HALT_STOP:  next_state = ST_STOP;
            default:    next_state = ST_RUN;
          endcase
        end
      end
      ST_CPU_ONLY_HALT, ST_OSC_RTC_ONLY_HALT:
        if (WAKE_REQ)
          next_state = ST_RUN;
      ST_STOP:
        if (WAKE_REQ)
          next_state = ST_WARM;
      ST_WARM:
        if (warm_done)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
    next_pin_oe_n = !PIN_DIR_BIT;
    if (PIN_DIR_BIT && PIN_FUNC_BIT)
      next_pin_out = clk_level;
    else if (state == ST_RUN)
      next_pin_out = PORT_DATA;
    else
      next_pin_out = held_data;
    if ((state == ST_STOP || state == ST_WARM) && !sys2[SYS2_DRIVE])
      next_pin_oe_n = 1'b1;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state     <= ST_RUN;
      held_data <= 1'b0;
      pin_out   <= 1'b0;
      pin_oe_n  <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      held_data <= next_held_data;
      pin_out   <= next_pin_out;
      pin_oe_n  <= next_pin_oe_n;
    end
  end

  assign RDATA      = rdata;
  assign PROTECT_ON = prot;
  assign PIN_OUT    = pin_out;
  assign PIN_OE_N   = pin_oe_n;
  assign PERIPH_TICK = per_tick;
  assign SYS_TICK   = sys_tick && state == ST_RUN;
  assign PRESC_TICK = presc_tick;
  assign CPU_RUN    = (state == ST_RUN);
  assign UNIT_RUN   = (state == ST_RUN)   ? {NUM_UNITS{1'b1}} :
                      (state == ST_CPU_ONLY_HALT) ? UNIT_IDLE_EN :
                      {NUM_UNITS{1'b0}};
  assign RTC_RUN    = (state != ST_STOP);
  assign HIGH_OSC_ENABLE = sys0[SYS0_HIGH_EN] &&
                           state != ST_STOP;
  assign LOW_OSC_ENABLE  = sys0[SYS0_LOW_EN] && state != ST_STOP;
  assign PORT_HOLD  = (state == ST_CPU_ONLY_HALT) || (state == ST_OSC_RTC_ONLY_HALT) ||
                      ((state == ST_STOP || state == ST_WARM) &&
                       sys2[SYS2_DRIVE]);

endmodule

// File: test/cgs_top_checker.sv
// Concurrent checks on the clock gear and standby controller ports
`timescale 1ns/1ps
module cgs_checker
  import cgs_pkg::*;
#(
  parameter int NUM_UNITS = 15
)
(
  input wire logic                  CORE_CLK,
  input wire logic                  RESET_N,
  input wire cgs_pkg::cgs_bus_req_t BUS,
  input wire logic [7:0]            RDATA,
  input wire logic                  HALT_EXEC,
  input wire logic                  PIN_DIR_BIT,
  input wire logic [NUM_UNITS-1:0]  UNIT_IDLE_EN,
  input wire logic                  HIGH_OSC_ENABLE,
  input wire logic                  LOW_OSC_ENABLE,
  input wire logic                  PERIPH_TICK,
  input wire logic                  SYS_TICK,
  input wire logic                  CPU_RUN,
  input wire logic [NUM_UNITS-1:0]  UNIT_RUN,
  input wire logic                  RTC_RUN,
  input wire logic                  PORT_HOLD,
  input wire logic                  PROTECT_ON,
  input wire logic                  PIN_OUT,
  input wire logic                  PIN_OE_N
);
  default clocking
    @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  key_lock_a: assert property (
    $past(BUS.wr && BUS.addr == KEY_ADDR)
    |-> PROTECT_ON == ($past(BUS.wdata) != KEY_UNLOCK))
    else $error("lock flag wrong after key write");
  stat_read_a: assert property (
    $past(BUS.rd && BUS.addr == STAT_ADDR)
    |-> RDATA[7] == $past(PROTECT_ON))
    else $error("status lock bit wrong");
  halt_entry_a: assert property (
    $fell(CPU_RUN) |-> $past(HALT_EXEC))
    else $error("cpu stopped without halt");
  idle_units_a: assert property (
    !CPU_RUN |-> (UNIT_RUN & ~UNIT_IDLE_EN) == '0)
    else $error("unit runs without its enable");
  run_units_a: assert property (
    CPU_RUN |-> (&UNIT_RUN) && RTC_RUN)
    else $error("block stopped in run");
  stop_all_a: assert property (
    !RTC_RUN |-> !CPU_RUN && UNIT_RUN == '0
      && !HIGH_OSC_ENABLE && !LOW_OSC_ENABLE)
    else $error("circuit active in stop");
  idle_hold_a: assert property (
    $fell(CPU_RUN) && RTC_RUN |-> PORT_HOLD)
    else $error("ports not held in idle");
  pin_dir_a: assert property (
    !PIN_OE_N |-> $past(PIN_DIR_BIT))
    else $error("pin driven while input");
  stop_pin_a: assert property (
    !RTC_RUN && !$past(RTC_RUN) && !$past(RTC_RUN, 2) |-> $stable(PIN_OUT))
    else $error("clock pin moves in stop");
  sys_tick_a: assert property (
    SYS_TICK |-> PERIPH_TICK && CPU_RUN)
    else $error("system tick off peripheral tick");
endmodule

bind cgs_top cgs_checker #(.NUM_UNITS(NUM_UNITS)) i_chk (
  .CORE_CLK(CORE_CLK),
  .RESET_N(RESET_N),
  .BUS(BUS),
  .RDATA(RDATA),
  .HALT_EXEC(HALT_EXEC),
  .PIN_DIR_BIT(PIN_DIR_BIT),
  .UNIT_IDLE_EN(UNIT_IDLE_EN),
  .HIGH_OSC_ENABLE(HIGH_OSC_ENABLE),
  .LOW_OSC_ENABLE(LOW_OSC_ENABLE),
  .PERIPH_TICK(PERIPH_TICK),
  .SYS_TICK(SYS_TICK),
  .CPU_RUN(CPU_RUN),
  .UNIT_RUN(UNIT_RUN),
  .RTC_RUN(RTC_RUN),
  .PORT_HOLD(PORT_HOLD),
  .PROTECT_ON(PROTECT_ON),
  .PIN_OUT(PIN_OUT),
  .PIN_OE_N(PIN_OE_N)
);

// File: test/tb_clock_gear_standby_control.sv
// Self-checking bench for the clock gear and standby controller
`timescale 1ns/1ps
module tb_clock_gear_standby_control;
  import cgs_pkg::*;
  localparam int NU = 15;
  logic          clk, rst_n, hi_tick, lo_tick, halt, wake;
  logic          dir, func, pdat, hi_en, lo_en, p_tick, s_tick, q_tick;
  logic          cpu_run, rtc_run, hold, prot, pin_out, pin_oe_n;
  logic [NU-1:0] idle_en, unit_run;
  logic [7:0]    rdata, r;
  cgs_bus_req_t  bus;
  int            fails, n_compared, p, s, q, t;
  int            cyc = 0;

  cgs_top #(.EXP_W18(4), .EXP_W16(3), .EXP_W14(2)) i_dut (
    .CORE_CLK(clk), .RESET_N(rst_n), .BUS(bus), .RDATA(rdata),
    .HIGH_OSC_TICK(hi_tick), .LOW_OSC_TICK(lo_tick), .HALT_EXEC(halt),
    .WAKE_REQ(wake), .PIN_DIR_BIT(dir), .PIN_FUNC_BIT(func),
    .PORT_DATA(pdat), .UNIT_IDLE_EN(idle_en), .HIGH_OSC_ENABLE(hi_en),
    .LOW_OSC_ENABLE(lo_en), .PERIPH_TICK(p_tick), .SYS_TICK(s_tick),
    .PRESC_TICK(q_tick), .CPU_RUN(cpu_run), .UNIT_RUN(unit_run),
    .RTC_RUN(rtc_run), .PORT_HOLD(hold), .PROTECT_ON(prot),
    .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n));

  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // Low oscillator tick every fourth cycle, plus hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    lo_tick <= (cyc % 4 == 0);
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_op(input logic [7:0] a, d, input logic w);
    @(posedge clk) bus <= '{a, d, w, !w};
    @(posedge clk) bus <= '0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, d);
    bus_op(a, d, 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] a, e);
    bus_op(a, 8'h00, 1'b0);
    chk(rdata, e);
  endtask

  task automatic count(input int n);
    logic last;
    p = 0;
    s = 0;
    q = 0;
    t = 0;
    last = pin_out;
    repeat (n)
    begin
      @(negedge clk);
      p += p_tick;
      s += s_tick;
      q += q_tick;
      t += (pin_out != last);
      last = pin_out;
    end
  endtask

  function automatic logic [NU-1:0] exp_units(int m, logic [NU-1:0] en);
    case (m)
      0: return '1;
      3: return en;
      default: return '0;
    endcase
  endfunction

  initial
  begin
    {rst_n, halt, wake, dir, func, pdat} = '0;
    {fails, n_compared} = '0;
    bus = '0;
    hi_tick = 1;
    idle_en = '0;
    void'($urandom(6219));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rd_chk(SYS0_ADDR, 8'h80);
    rd_chk(SYS1_ADDR, 8'h00);
    rd_chk(SYS2_ADDR, SYS2_RST);
    rd_chk(STAT_ADDR, 8'h23);
    rd_chk(KEY_ADDR, 8'h00);
    rd_chk(8'h10, 8'h00);
    $display("test reset done");
    r = 8'($urandom());
    wr(KEY_ADDR, r | 8'h20);
    chk(prot, 1);
    rd_chk(STAT_ADDR, 8'hA3);
    wr(SYS0_ADDR, 8'h00);
    wr(SYS1_ADDR, r);
    wr(SYS2_ADDR, r);
    rd_chk(SYS0_ADDR, 8'h80);
    rd_chk(SYS1_ADDR, 8'h00);
    rd_chk(SYS2_ADDR, SYS2_RST);
    wr(KEY_ADDR, 8'h1F);
    chk(prot, 0);
    wr(SYS1_ADDR, r);
    rd_chk(SYS1_ADDR, r & 8'h0F);
    wr(SYS1_ADDR, 8'h00);
    repeat (20) @(posedge clk);
    $display("test protection done");
    wr(SYS0_ADDR, 8'hC4);
    repeat (8) @(posedge clk);
    rd_chk(SYS0_ADDR, 8'hC4);
    chk({hi_en, lo_en}, 2'b11);
    count(16);
    chk(s, 8);
    rd_chk(SYS0_ADDR, 8'hC0);
    wr(SYS0_ADDR, 8'h80);
    $display("test warm-up done");
    @(posedge clk) {dir, func} <= 2'b11;
    wr(SYS2_ADDR, 8'h60);
    for (int g = 0; g < 5; g++)
    begin
      wr(SYS1_ADDR, g[7:0]);
      wr(8'h10, 8'h00);
      repeat (20) @(posedge clk);
      count(64);
      chk(p, 64 >> g);
      chk(s, 32 >> g);
      chk(t, 32 >> g);
      chk(q, 32 >> g);
    end
    wr(SYS1_ADDR, 8'h00);
    wr(SYS0_ADDR, 8'h82);
    repeat (20) @(posedge clk);
    count(128);
    chk(q, 2);
    wr(SYS0_ADDR, 8'h80);
    wr(SYS2_ADDR, 8'h20);
    repeat (4) @(posedge clk);
    count(64);
    chk(t, 16);
    @(posedge clk) {func, pdat} <= {1'b0, r[0]};
    repeat (3) @(negedge clk);
    chk({pin_out, pin_oe_n}, {r[0], 1'b0});
    @(posedge clk) {dir, func} <= 2'b01;
    repeat (3) @(negedge clk);
    chk(pin_oe_n, 1);
    @(posedge clk) {dir, func} <= 2'b11;
    $display("test clock output done");
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk) idle_en <= NU'($urandom());
      wr(SYS2_ADDR, 8'h60 | (m[7:0] << 2));
      @(posedge clk) halt <= 1;
      @(posedge clk) halt <= 0;
      #1;
      chk(cpu_run, m == 0);
      chk(rtc_run, m != 1);
      chk(unit_run, exp_units(m, idle_en));
      chk(hold, m[1]);
      chk(hi_en, m != 1);
      repeat (3) @(negedge clk);
      r[0] = pin_out;
      repeat (8) @(negedge clk);
      if (m == 1)
      begin
        chk(pin_out, r[0]);
        chk(pin_oe_n, 1);
      end
      @(posedge clk) wake <= 1;
      @(posedge clk) wake <= 0;
      for (int k = 0; k < 200 && cpu_run !== 1'b1; k++)
        @(posedge clk);
      #1;
      chk(cpu_run, 1);
      $display("test halt mode %0d done", m);
    end
    close_out();
  end
endmodule
